// File: bench/tape_mech_model.sv
// behavioural paper tape mechanism that drives the reader sensor pins
`timescale 1ns/100ps
module tape_mech_model #(
    parameter int LINE = 40
) (
    // clock
    input  wire logic       sys_clk,
    // motor from the block, tape length from the bench
    input  wire logic       motor_run,
    input  wire logic [4:0] tape_len,
    // sensor pins
    output logic [7:0]      line_holes,
    output logic            feed_hole,
    output logic            tape_material
);
    logic [7:0] tape_img [0:15];
    int         cnt = 0;
    int         idx = 0;

    ////////////////////////////////////////////////////////////////////////
    // tape image: two text lines, then binary frames with one skipped line
    initial begin
        tape_img = '{8'ha5, 8'h3c, 8'h81, 8'h3f, 8'hbf, 8'h80, 8'h95, 8'ha4,
                     8'hea, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    end

    ////////////////////////////////////////////////////////////////////////
    // one line per LINE cycles of motion, moved midway so a sample never
    // lands on a changing line; coasting after a stop passes a sampled line
    always @(posedge sys_clk) begin
        if (motor_run) begin
            cnt <= cnt + 1;
            if (cnt > LINE && cnt % LINE == LINE / 2) begin
                idx <= idx + 1;
            end
        end else begin
            cnt <= 0;
            if (cnt >= LINE && cnt % LINE < LINE / 2) begin
                idx <= idx + 1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // past the end light reaches every cell but no material is sensed
    assign tape_material = (idx < tape_len);
    assign feed_hole     = 1'b1;
    assign line_holes    = tape_material ? tape_img[idx[3:0]] : 8'hff;
endmodule

// File: bench/tape_reader_unit_tb_top.sv
// self-checking bench for the paper tape reader interface
`timescale 1ns/100ps
module tape_reader_unit_tb_top;
    import tape_reader_pkg::*;
    logic              sys_clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic [8:0]        dev_code = 9'h000;
    logic              conditions_out_write = 1'b0;
    logic              conditions_in_read = 1'b0;
    logic              data_in_read = 1'b0;
    logic [WORD_W-1:0] io_wdata = '0;
    logic [WORD_W-1:0] io_rdata;
    logic              io_rvalid;
    logic [7:1]        pi_request;
    logic [7:0]        line_holes;
    logic              feed_hole;
    logic              tape_material;
    logic              feed_switch = 1'b0;
    logic              motor_run;
    logic [4:0]        tape_len = 5'h09;
    int                bad_count = 0;
    int                checks_done = 0;
    logic [WORD_W-1:0] rd;

    always #20 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////
    // short counts keep the run brief; grace must exceed the bench's gap
    tape_reader_unit #(.LINE_CYCLES(40), .GRACE_CYCLES(10), .RESTART_CYCLES(30))
    i_tape_reader_unit (.sys_clk(sys_clk), .sys_rst(sys_rst), .dev_code(dev_code),
        .conditions_out_write(conditions_out_write), .conditions_in_read(conditions_in_read),
        .data_in_read(data_in_read), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_rvalid(io_rvalid), .pi_request(pi_request), .line_holes(line_holes),
        .feed_hole(feed_hole), .tape_material(tape_material), .feed_switch(feed_switch),
        .motor_run(motor_run));

    tape_mech_model #(.LINE(40)) i_tape_mech_model (.sys_clk(sys_clk),
        .motor_run(motor_run), .tape_len(tape_len), .line_holes(line_holes),
        .feed_hole(feed_hole), .tape_material(tape_material));

    ////////////////////////////////////////////////////////////////////////
    // comparison and closing
    task automatic chk(input string name, input logic [WORD_W-1:0] exp,
                       input logic [WORD_W-1:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // bus cycles: strobe for one edge, answer sampled just after the next
    task automatic ctl_write(input logic [8:0] dev, input logic [5:0] val);
        @(posedge sys_clk);
        #1;
        dev_code = dev;
        io_wdata = {30'h0, val};
        conditions_out_write = 1'b1;
        @(posedge sys_clk);
        #1;
        conditions_out_write = 1'b0;
    endtask

    task automatic bus_rd(input bit data, input logic [8:0] dev, input logic exp_valid);
        @(posedge sys_clk);
        #1;
        dev_code = dev;
        conditions_in_read = !data;
        data_in_read = data;
        @(posedge sys_clk);
        #1;
        conditions_in_read = 1'b0;
        data_in_read = 1'b0;
        rd = io_rdata;
        chk("io_rvalid", {35'h0, exp_valid}, {35'h0, io_rvalid});
    endtask

    task automatic wait_pi(input logic [7:1] exp);
        int n;
        for (n = 0; n < 3000 && pi_request === 7'h00; n++) begin
            @(posedge sys_clk);
        end
        if (n == 3000) begin
            chk("pi wait", 36'h1, 36'h0);
            wrap_up();
        end else begin
            #1;
            chk("pi_request", {29'h0, exp}, {29'h0, pi_request});
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_idle_and_decode;
        bus_rd(0, DEV_CODE, 1'b1);
        chk("status after reset", 36'h0, rd);
        ctl_write(9'h045, 6'h1f);
        bus_rd(0, 9'h045, 1'b0);
        bus_rd(0, DEV_CODE, 1'b1);
        chk("status foreign write", 36'h0, rd);
    endtask

    task automatic t_fields;
        ctl_write(DEV_CODE, 6'h08);
        bus_rd(0, DEV_CODE, 1'b1);
        chk("status done only", 36'h8, rd);
        chk("pi chan zero", 36'h0, {29'h0, pi_request});
        ctl_write(DEV_CODE, 6'h0d);
        wait_pi(7'h10);
        ctl_write(DEV_CODE, 6'h00);
        bus_rd(0, DEV_CODE, 1'b1);
        chk("status cleared", 36'h0, rd);
    endtask

    task automatic t_alpha_then_binary;
        ctl_write(DEV_CODE, 6'h13);
        wait_pi(7'h04);
        chk("motor at first line", 36'h1, {35'h0, motor_run});
        bus_rd(0, DEV_CODE, 1'b1);
        chk("status line done", 36'h10b, rd);
        bus_rd(1, DEV_CODE, 1'b1);
        chk("first text line", 36'ha5, rd);
        bus_rd(0, DEV_CODE, 1'b1);
        chk("status restarted", 36'h113, rd);
        wait_pi(7'h04);
        bus_rd(1, DEV_CODE, 1'b1);
        chk("second text line", 36'h3c, rd);
        ctl_write(DEV_CODE, 6'h33);
        wait_pi(7'h04);
        bus_rd(1, DEV_CODE, 1'b1);
        chk("binary word", {6'h01, 6'h3f, 6'h00, 6'h15, 6'h24, 6'h2a}, rd);
    endtask

    task automatic t_out_of_tape;
        int n;
        rd = 36'h10;
        for (n = 0; n < 100 && rd[FLD_BUSY] !== 1'b0; n++) begin
            bus_rd(0, DEV_CODE, 1'b1);
        end
        if (rd[FLD_BUSY] !== 1'b0) begin
            chk("run out wait", 36'h1, 36'h0);
            wrap_up();
        end
        chk("status run out", 36'h23, rd);
        chk("no done on run out", 36'h0, {29'h0, pi_request});
    endtask

    task automatic t_operator_feed;
        tape_len = 5'h10;
        #1000;
        @(posedge sys_clk);
        #1;
        chk("motor stopped", 36'h0, {35'h0, motor_run});
        feed_switch = 1'b1;
        wait_pi(7'h04);
        bus_rd(0, DEV_CODE, 1'b1);
        chk("status fed", 36'h12b, rd);
        feed_switch = 1'b0;
        ctl_write(DEV_CODE, 6'h03);
        bus_rd(0, DEV_CODE, 1'b1);
        chk("status stopped", 36'h103, rd);
        // a read given after the grace window pays the full restart delay
        ctl_write(DEV_CODE, 6'h13);
        wait_pi(7'h04);
        repeat (20) @(posedge sys_clk);
        #1;
        chk("motor after late read", 36'h0, {35'h0, motor_run});
        bus_rd(1, DEV_CODE, 1'b1);
        chk("blank line", 36'h0, rd);
        repeat (20) @(posedge sys_clk);
        #1;
        chk("restart delay", 36'h0, {35'h0, motor_run});
        wait_pi(7'h04);
        ctl_write(DEV_CODE, 6'h03);
        // operator runs the tape out of the reader
        tape_len = 5'h00;
        feed_switch = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        feed_switch = 1'b0;
        bus_rd(0, DEV_CODE, 1'b1);
        chk("status run out by feed", 36'h3, rd);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        t_idle_and_decode();
        t_fields();
        t_alpha_then_binary();
        t_out_of_tape();
        t_operator_feed();
        wrap_up();
    end
endmodule

// File: hw/pin_sync.sv
// two-stage synchroniser for the reader pins
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    // pins in, synchronised levels out
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);
    logic [W-1:0] stage1_reg;

    // first stage feeds only the second stage
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stage1_reg <= '0;
            pin_out    <= '0;
        end else begin
            stage1_reg <= pin_in;
            pin_out    <= stage1_reg;
        end
    end
endmodule

// File: hw/tape_reader_pkg.sv
// constants shared by the paper tape reader interface
package tape_reader_pkg;
    // device select: octal 104 on the nine-bit device code field
    localparam logic [8:0] DEV_CODE     = 9'h044;
    // word layout: index 0 is the rightmost word bit, index 35 the leftmost
    localparam int         WORD_W       = 36;
    localparam int         FLD_CHAN_LO  = 0;
    localparam int         FLD_CHAN_HI  = 2;
    localparam int         FLD_DONE     = 3;
    localparam int         FLD_BUSY     = 4;
    localparam int         FLD_BINARY   = 5;
    localparam int         FLD_TAPE     = 8;
    // tape line layout: index 0 is channel 1
    localparam int         CHANNELS     = 8;
    localparam int         FRAME_W      = 6;
    localparam int         CH8_BIT      = 7;
    localparam logic [2:0] FRAMES_BIN   = 3'h6;
    // control reset values
    localparam logic [2:0] CHAN_RESET   = 3'h0;
    // timing
    localparam int         CLK_HZ       = 25_000_000;
    localparam int         LINE_RATE_HZ = 300;
    localparam int         GRACE_US     = 1600;
    localparam int         RESTART_MS   = 40;
    localparam int         LINE_CYC     = CLK_HZ / LINE_RATE_HZ;
    localparam int         GRACE_CYC    = GRACE_US * (CLK_HZ / 1_000_000);
    localparam int         RESTART_CYC  = RESTART_MS * (CLK_HZ / 1000);
    localparam int         CNT_W        = 20;
    // tape motion states
    typedef enum logic [2:0] {
        ST_STOP = 3'b001,
        ST_SPIN = 3'b010,
        ST_RUN  = 3'b100
    } motion_t;
endpackage

// File: hw/tape_reader_unit.sv
// paper tape reader interface: control, status, line assembly and tape motion
`timescale 1ns/100ps
// How it works
// - binary flag selects alphanumeric or binary reading
// - alphanumeric line goes to bits 28-35
// - binary takes six channel-8 lines, channels 1-6
// - first line leftmost, channel 1 rightmost bit
// - conditions out loads binary, busy, done, channel
// - conditions in returns tape flag and control
// - tape flag sets on motion, stays while tape
// - operator feed rising tape flag sets done
// - bit 27 zero after out-of-tape read
// - data in returns buffer, clears done, sets busy
// - busy set clears buffer, sets tape, moves tape
// - enough lines read: clear busy, set done, interrupt
// - tape flag clears on run-out, in a read or by operator feed
// - tape moves at 300 lines per second
// - late data in stops reader for 40 ms
// - end of tape is missing material between holes
// - answer only device code 104
module tape_reader_unit
    import tape_reader_pkg::*;
#(
    parameter int LINE_CYCLES    = LINE_CYC,
    parameter int GRACE_CYCLES   = GRACE_CYC,
    parameter int RESTART_CYCLES = RESTART_CYC
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // in-out bus from the processor
    input  wire logic [8:0]        dev_code,
    input  wire logic              conditions_out_write,
    input  wire logic              conditions_in_read,
    input  wire logic              data_in_read,
    input  wire logic [WORD_W-1:0] io_wdata,
    output logic      [WORD_W-1:0] io_rdata,
    output logic                   io_rvalid,
    output logic      [7:1]        pi_request,
    // reader mechanism pins
    input  wire logic [CHANNELS-1:0] line_holes,
    input  wire logic              feed_hole,
    input  wire logic              tape_material,
    input  wire logic              feed_switch,
    output logic                   motor_run
);
    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisation
    logic [CHANNELS-1:0] holes_s;
    logic                feed_s;
    logic                material_s;
    logic                switch_s;

    pin_sync #(
        .W (CHANNELS + 3)
    ) i_pin_sync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .pin_in  ({line_holes, feed_hole, tape_material, feed_switch}),
        .pin_out ({holes_s, feed_s, material_s, switch_s})
    );

    ////////////////////////////////////////////////////////////////////////////////
    // state
    logic              binary_reg;
    logic              busy_reg;
    logic              done_reg;
    logic [2:0]        chan_reg;
    logic              tape_reg;
    logic [WORD_W-1:0] buf_reg;
    logic [2:0]        frame_reg;
    motion_t           motion_reg;
    logic [CNT_W-1:0]  wait_reg;
    logic [CNT_W-1:0]  line_cnt_reg;
    logic              busy_next;

    // one-hot channel decode, zero channel means no request
    function automatic logic [7:1] chan_onehot(input logic [2:0] ch);
        logic [7:1] v;
        v = '0;
        if (ch != 3'h0) begin
            v[ch] = 1'b1;
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode and line events
    logic addressed;
    logic ctl_wr_hit;
    logic stat_rd_hit;
    logic buf_rd_hit;
    logic line_tick;
    logic eot_event;
    logic take_line;
    logic read_complete;
    logic busy_start;
    logic feed_motion;
    logic feed_rise;
    logic runout_event;

    assign addressed  = (dev_code == DEV_CODE);
    assign ctl_wr_hit  = conditions_out_write & addressed;
    assign stat_rd_hit = conditions_in_read & addressed;
    assign buf_rd_hit  = data_in_read & addressed;

    // one line position passes per tick while the motor runs
    assign line_tick  = (motion_reg == ST_RUN)
                        && (line_cnt_reg == CNT_W'(LINE_CYCLES - 1));
    // no material at a line position means the tape is gone
    assign eot_event  = line_tick & busy_reg & ~material_s;
    // binary skips lines without channel 8
    assign take_line  = line_tick & busy_reg & material_s & feed_s
                        & (~binary_reg | holes_s[CH8_BIT]);
    assign read_complete = take_line
                        & (~binary_reg | (frame_reg == FRAMES_BIN - 3'h1));
    // operator feed: motion without a read in progress
    assign feed_motion  = switch_s & ~busy_reg;
    assign feed_rise    = feed_motion & material_s & ~tape_reg;
    assign runout_event = feed_motion & ~material_s & tape_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // busy: data in sets it, completion and out-of-tape clear it
    always_comb begin
        busy_next = busy_reg;
        if (read_complete || eot_event) begin
            busy_next = 1'b0;
        end
        if (ctl_wr_hit) begin
            busy_next = io_wdata[FLD_BUSY];
        end
        if (buf_rd_hit) begin
            busy_next = 1'b1;
        end
    end

    assign busy_start = busy_next & ~busy_reg;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= busy_next;
        end
    end

    // binary flag and channel assignment come only from conditions out
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            binary_reg <= 1'b0;
            chan_reg   <= CHAN_RESET;
        end else if (ctl_wr_hit) begin
            binary_reg <= io_wdata[FLD_BINARY];
            chan_reg   <= io_wdata[FLD_CHAN_HI:FLD_CHAN_LO];
        end
    end

    // done: hardware set wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            done_reg <= 1'b0;
        end else if (read_complete || feed_rise) begin
            done_reg <= 1'b1;
        end else if (buf_rd_hit) begin
            done_reg <= 1'b0;
        end else if (ctl_wr_hit) begin
            done_reg <= io_wdata[FLD_DONE];
        end
    end

    // tape flag tracks whether tape is in the reader
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tape_reg <= 1'b0;
        end else if (eot_event || runout_event) begin
            tape_reg <= 1'b0;
        end else if (busy_start || (feed_motion && material_s)) begin
            tape_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // buffer assembly; shifting left puts the first frame leftmost
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            buf_reg   <= '0;
            frame_reg <= 3'h0;
        end else if (busy_start) begin
            buf_reg   <= '0;
            frame_reg <= 3'h0;
        end else if (take_line) begin
            frame_reg <= frame_reg + 3'h1;
            if (binary_reg) begin
                buf_reg <= {buf_reg[WORD_W-FRAME_W-1:0], holes_s[FRAME_W-1:0]};
            end else begin
                buf_reg <= {{(WORD_W - CHANNELS){1'b0}}, holes_s};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // tape motion: run, coast through the grace window, then stop and spin up
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            motion_reg <= ST_STOP;
            wait_reg   <= '0;
        end else begin
            case (motion_reg)
                ST_STOP: begin
                    wait_reg <= '0;
                    if (busy_reg) begin
                        motion_reg <= ST_SPIN;
                    end
                end
                ST_SPIN: begin
                    // a stopped reader pays the full restart delay
                    if (wait_reg == CNT_W'(RESTART_CYCLES - 1)) begin
                        motion_reg <= ST_RUN;
                        wait_reg   <= '0;
                    end else begin
                        wait_reg <= wait_reg + 1'b1;
                    end
                end
                ST_RUN: begin
                    if (busy_reg) begin
                        wait_reg <= '0;
                    end else if (wait_reg == CNT_W'(GRACE_CYCLES - 1)) begin
                        motion_reg <= ST_STOP;
                        wait_reg   <= '0;
                    end else begin
                        wait_reg <= wait_reg + 1'b1;
                    end
                end
                default: begin
                    motion_reg <= ST_STOP;
                    wait_reg   <= '0;
                end
            endcase
        end
    end

    // line position pacing, held in phase only while running
    always_ff @(posedge sys_clk) begin
        if (sys_rst || motion_reg != ST_RUN || line_tick) begin
            line_cnt_reg <= '0;
        end else begin
            line_cnt_reg <= line_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            motor_run <= 1'b0;
        end else begin
            motor_run <= (motion_reg == ST_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read answers, one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            io_rdata  <= '0;
            io_rvalid <= 1'b0;
        end else begin
            io_rvalid <= stat_rd_hit | buf_rd_hit;
            if (buf_rd_hit) begin
                io_rdata <= buf_reg;
            end else if (stat_rd_hit) begin
                io_rdata <= {{(WORD_W - FLD_TAPE - 1){1'b0}}, tape_reg, 2'b00,
                             binary_reg, busy_reg, done_reg, chan_reg};
            end
        end
    end

    // interrupt request follows done on the assigned channel
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pi_request <= '0;
        end else begin
            pi_request <= done_reg ? chan_onehot(chan_reg) : 7'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    conditions_out_write_load_a: assert property (ctl_wr_hit |=> binary_reg == $past(io_wdata[FLD_BINARY])
        && chan_reg == $past(io_wdata[FLD_CHAN_HI:FLD_CHAN_LO]))
        else $error("control fields not loaded");
    conditions_in_read_format_a: assert property (stat_rd_hit && !buf_rd_hit |=> io_rvalid
        && io_rdata[FLD_TAPE] == $past(tape_reg) && io_rdata[FLD_BUSY] == $past(busy_reg))
        else $error("status word wrong");
    data_in_read_word_a: assert property (buf_rd_hit |=> io_rvalid && busy_reg
        && io_rdata == $past(buf_reg))
        else $error("data in did not return buffer");
    foreign_code_a: assert property (!addressed |=> !io_rvalid && $stable(chan_reg))
        else $error("foreign device code answered");
    busy_start_a: assert property (busy_start |=> buf_reg == '0 && tape_reg)
        else $error("busy start did not clear buffer");
    alpha_line_a: assert property (take_line && !binary_reg |=> done_reg && !busy_reg
        && buf_reg[CHANNELS-1:0] == $past(holes_s))
        else $error("alphanumeric line misplaced");
    binary_pack_a: assert property (take_line && binary_reg
        |=> buf_reg == {$past(buf_reg[WORD_W-FRAME_W-1:0]), $past(holes_s[FRAME_W-1:0])})
        else $error("binary frame misplaced");
    skip_frame_a: assert property (line_tick && busy_reg && binary_reg && !holes_s[CH8_BIT]
        |=> $stable(buf_reg) && $stable(frame_reg))
        else $error("line without channel 8 taken");
    eot_clear_a: assert property (eot_event |=> !tape_reg && !busy_reg)
        else $error("tape flag kept after run-out");
    no_irq_a: assert property (chan_reg == 3'h0 |=> pi_request == 7'h00)
        else $error("request on channel zero");
    stop_grace_a: assert property (motion_reg == ST_RUN ##1 motion_reg == ST_STOP
        |-> $past(wait_reg) == CNT_W'(GRACE_CYCLES - 1))
        else $error("stopped before grace ran out");

    alpha_done_c: cover property (read_complete && !binary_reg);
    binary_done_c: cover property (read_complete && binary_reg);
    runout_c: cover property (eot_event);
    restart_c: cover property (motion_reg == ST_SPIN ##1 motion_reg == ST_RUN);
endmodule
